// ### verilog/uccp_defs.vh
// Constants for the serial clock source and prescaler block.
// Assumes a 32-bit byte address and 16-bit registers in the low data bits.
`ifndef UCCP_DEFS_VH
`define UCCP_DEFS_VH

// ==========================================================================
// Register byte addresses
`define UCCP_ADDR_CH0_CTRL   32'h50000004
`define UCCP_ADDR_CH1_CTRL   32'h50004004
`define UCCP_ADDR_CH2_CTRL   32'h50008004
`define UCCP_ADDR_CH0_BAUD   32'h50000028
`define UCCP_ADDR_CH1_BAUD   32'h50004028
`define UCCP_ADDR_CH2_BAUD   32'h50008028
`define UCCP_ADDR_STATUS     32'h5000C000

// ==========================================================================
// Reset values
`define UCCP_CTRL_RESET      16'h0000
`define UCCP_BAUD_RESET      16'h0000
`define UCCP_RDATA_ZERO      32'h00000000

// ==========================================================================
// Control register fields
`define UCCP_DIV_HI          15
`define UCCP_DIV_LO          12
`define UCCP_DIV2_HI         14
`define UCCP_PRE_EN_BIT      15
`define UCCP_SEL_HI          11
`define UCCP_SEL_LO          10

// Source select codes
`define UCCP_SEL_PBUS_A      2'h0
`define UCCP_SEL_EXT         2'h1
`define UCCP_SEL_PBUS_B      2'h2
`define UCCP_SEL_CORE_DIV    2'h3

// ==========================================================================
// Prescaler ratios
`define UCCP_CH0_OFFSET      6'h06
`define UCCP_CH1_OFFSET      6'h15
`define UCCP_CH2_OFFSET      6'h24
`define UCCP_ALL_ZERO_RATIO  6'h2C
`define UCCP_RATIO_W         6

// ==========================================================================
// Baud generation
`define UCCP_OVERSAMPLE_MAX  4'hF

`endif

// ### verilog/uccp_prescaler.v
// Core clock prescaler: emits one tick every ratio cycles of the core clock.
// Assumes ratio and enable are static register outputs in the clock domain.
`timescale 1ns/100ps
`include "uccp_defs.vh"

module uccp_prescaler (
  // Clock and reset
  input  wire       clock,
  input  wire       rstn,
  // Control
  input  wire       enable,
  input  wire [5:0] ratio,
  // Divided core clock tick
  output reg        tick_reg
);

  reg [5:0] count_reg;
  reg [5:0] ratio_seen_reg;
  reg       enable_seen_reg;
  wire      restart;

  assign restart = (ratio != ratio_seen_reg) || (enable != enable_seen_reg);

  // ========================================================================
  // Counter
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count_reg       <= 6'h00;
      ratio_seen_reg  <= `UCCP_ALL_ZERO_RATIO;
      enable_seen_reg <= 1'b0;
      tick_reg        <= 1'b0;
    end else begin
      ratio_seen_reg  <= ratio;
      enable_seen_reg <= enable;
      if (restart || !enable) begin
        count_reg <= 6'h00;
        tick_reg  <= 1'b0;
      end else if (count_reg == ratio - 6'h01) begin
        count_reg <= 6'h00;
        tick_reg  <= 1'b1;
      end else begin
        count_reg <= count_reg + 6'h01;
        tick_reg  <= 1'b0;
      end
    end
  end

endmodule

// ### verilog/uccp_baud_gen.v
// Baud generator for one channel: source ticks divided by 16*(divisor+1).
// Assumes src_tick is a one-cycle pulse per source clock period.
`timescale 1ns/100ps
`include "uccp_defs.vh"

module uccp_baud_gen (
  // Clock and reset
  input  wire        clock,
  input  wire        rstn,
  // Source and setting
  input  wire        src_tick,
  input  wire        restart,
  input  wire [15:0] divisor,
  // Baud tick
  output reg         baud_tick_reg
);

  reg [3:0]  over_reg;
  reg [15:0] div_cnt_reg;

  // ========================================================================
  // Oversample and divisor counters
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      over_reg      <= 4'h0;
      div_cnt_reg   <= 16'h0000;
      baud_tick_reg <= 1'b0;
    end else begin
      baud_tick_reg <= 1'b0;
      if (restart) begin
        over_reg    <= 4'h0;
        div_cnt_reg <= 16'h0000;
      end else if (src_tick) begin
        if (over_reg == `UCCP_OVERSAMPLE_MAX) begin
          over_reg <= 4'h0;
          if (div_cnt_reg >= divisor) begin
            div_cnt_reg   <= 16'h0000;
            baud_tick_reg <= 1'b1;
          end else begin
            div_cnt_reg <= div_cnt_reg + 16'h0001;
          end
        end else begin
          over_reg <= over_reg + 4'h1;
        end
      end
    end
  end

endmodule

// ### verilog/uccp_top.v
// Serial clock source selection and core clock prescaler for three channels.
// Assumes a single-cycle register port; pbus_tick marks each peripheral clock.
`timescale 1ns/100ps
`include "uccp_defs.vh"

module uccp_top (
  // Clock and reset
  input  wire        clock,
  input  wire        rstn,
  // Register port
  input  wire [31:0] addr,
  input  wire [31:0] wr_data,
  input  wire        wr_strobe,
  input  wire        rd_strobe,
  output reg  [31:0] rd_data_reg,
  // Clock sources
  input  wire        pbus_tick,
  input  wire        external_serial_clock_in,
  // Derived clocks
  output wire        divided_core_tick,
  output wire        baud_tick0,
  output wire        baud_tick1,
  output wire        baud_tick2
);

  // ========================================================================
  // Registers
  reg [15:0] serial_ch0_control;
  reg [15:0] serial_ch1_control;
  reg [15:0] serial_ch2_control;
  reg [15:0] baud_divisor0;
  reg [15:0] baud_divisor1;
  reg [15:0] baud_divisor2;
  reg        ext_q_reg;
  reg        ext_rise_reg;

  wire [5:0] ratio;
  wire       pre_enable;
  wire       pre_tick;
  wire       src0;
  wire       src1;
  wire       src2;
  wire       restart0;
  wire       restart1;
  wire       restart2;

  // ========================================================================
  // Functions
  function src_pick;
    input [1:0] sel;
    input       bus_t;
    input       ext_t;
    input       pre_t;
    begin
      case (sel)
        `UCCP_SEL_EXT:      src_pick = ext_t;
        `UCCP_SEL_CORE_DIV: src_pick = pre_t;
        default:            src_pick = bus_t;
      endcase
    end
  endfunction

  function [5:0] ratio_of;
    input [3:0] d0;
    input [3:0] d1;
    input [2:0] d2;
    begin
      if (d0 != 4'h0)
        ratio_of = `UCCP_CH0_OFFSET + {2'h0, d0};
      else if (d1 != 4'h0)
        ratio_of = `UCCP_CH1_OFFSET + {2'h0, d1};
      else if (d2 != 3'h0)
        ratio_of = `UCCP_CH2_OFFSET + {3'h0, d2};
      else
        ratio_of = `UCCP_ALL_ZERO_RATIO;
    end
  endfunction

  // ========================================================================
  // Register writes
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      serial_ch0_control <= `UCCP_CTRL_RESET;
      serial_ch1_control <= `UCCP_CTRL_RESET;
      serial_ch2_control <= `UCCP_CTRL_RESET;
      baud_divisor0      <= `UCCP_BAUD_RESET;
      baud_divisor1      <= `UCCP_BAUD_RESET;
      baud_divisor2      <= `UCCP_BAUD_RESET;
    end else if (wr_strobe) begin
      case (addr)
        `UCCP_ADDR_CH0_CTRL: serial_ch0_control <= wr_data[15:0];
        `UCCP_ADDR_CH1_CTRL: serial_ch1_control <= wr_data[15:0];
        `UCCP_ADDR_CH2_CTRL: serial_ch2_control <= wr_data[15:0];
        `UCCP_ADDR_CH0_BAUD: baud_divisor0      <= wr_data[15:0];
        `UCCP_ADDR_CH1_BAUD: baud_divisor1      <= wr_data[15:0];
        `UCCP_ADDR_CH2_BAUD: baud_divisor2      <= wr_data[15:0];
        default: begin
        end
      endcase
    end
  end

  // ========================================================================
  // Register reads, data valid the cycle after the strobe
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rd_data_reg <= `UCCP_RDATA_ZERO;
    end else if (rd_strobe) begin
      case (addr)
        `UCCP_ADDR_CH0_CTRL: rd_data_reg <= {16'h0000, serial_ch0_control};
        `UCCP_ADDR_CH1_CTRL: rd_data_reg <= {16'h0000, serial_ch1_control};
        `UCCP_ADDR_CH2_CTRL: rd_data_reg <= {16'h0000, serial_ch2_control};
        `UCCP_ADDR_CH0_BAUD: rd_data_reg <= {16'h0000, baud_divisor0};
        `UCCP_ADDR_CH1_BAUD: rd_data_reg <= {16'h0000, baud_divisor1};
        `UCCP_ADDR_CH2_BAUD: rd_data_reg <= {16'h0000, baud_divisor2};
        `UCCP_ADDR_STATUS:   rd_data_reg <= {25'h0000000, pre_enable, ratio};
        default:             rd_data_reg <= `UCCP_RDATA_ZERO;
      endcase
    end else begin
      rd_data_reg <= `UCCP_RDATA_ZERO;
    end
  end

  // ========================================================================
  // External clock edge detect
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ext_q_reg    <= 1'b0;
      ext_rise_reg <= 1'b0;
    end else begin
      ext_q_reg    <= external_serial_clock_in;
      ext_rise_reg <= external_serial_clock_in & ~ext_q_reg;
    end
  end

  // ========================================================================
  // Prescaler
  assign ratio = ratio_of(serial_ch0_control[`UCCP_DIV_HI:`UCCP_DIV_LO],
                          serial_ch1_control[`UCCP_DIV_HI:`UCCP_DIV_LO],
                          serial_ch2_control[`UCCP_DIV2_HI:`UCCP_DIV_LO]);
  assign pre_enable = serial_ch2_control[`UCCP_PRE_EN_BIT];

  uccp_prescaler u_pre (
    .clock    (clock),
    .rstn     (rstn),
    .enable   (pre_enable),
    .ratio    (ratio),
    .tick_reg (pre_tick)
  );

  assign divided_core_tick = pre_tick;

  // ========================================================================
  // Per-channel source select and baud generation
  assign src0 = src_pick(serial_ch0_control[`UCCP_SEL_HI:`UCCP_SEL_LO],
                         pbus_tick, ext_rise_reg, pre_tick);
  assign src1 = src_pick(serial_ch1_control[`UCCP_SEL_HI:`UCCP_SEL_LO],
                         pbus_tick, ext_rise_reg, pre_tick);
  assign src2 = src_pick(serial_ch2_control[`UCCP_SEL_HI:`UCCP_SEL_LO],
                         pbus_tick, ext_rise_reg, pre_tick);

  assign restart0 = wr_strobe && (addr == `UCCP_ADDR_CH0_BAUD);
  assign restart1 = wr_strobe && (addr == `UCCP_ADDR_CH1_BAUD);
  assign restart2 = wr_strobe && (addr == `UCCP_ADDR_CH2_BAUD);

  uccp_baud_gen u_baud0 (
    .clock         (clock),
    .rstn          (rstn),
    .src_tick      (src0),
    .restart       (restart0),
    .divisor       (baud_divisor0),
    .baud_tick_reg (baud_tick0)
  );

  uccp_baud_gen u_baud1 (
    .clock         (clock),
    .rstn          (rstn),
    .src_tick      (src1),
    .restart       (restart1),
    .divisor       (baud_divisor1),
    .baud_tick_reg (baud_tick1)
  );

  uccp_baud_gen u_baud2 (
    .clock         (clock),
    .rstn          (rstn),
    .src_tick      (src2),
    .restart       (restart2),
    .divisor       (baud_divisor2),
    .baud_tick_reg (baud_tick2)
  );

endmodule

// ### dv/uccp_top_assertions.sv
// Checker for uccp_top: register read timing, prescaler and baud tick spacing.
// Assumes it is bound to uccp_top and sees only that module's ports.
`timescale 1ns/100ps
`include "uccp_defs.vh"

module uccp_top_chk (
  // Clock and reset
  input logic        clock,
  input logic        rstn,
  // Register port
  input logic [31:0] addr,
  input logic [31:0] wr_data,
  input logic        wr_strobe,
  input logic        rd_strobe,
  input logic [31:0] rd_data_reg,
  // Derived clocks
  input logic        divided_core_tick,
  input logic        baud_tick0,
  input logic        baud_tick1,
  input logic        baud_tick2
);
  logic [15:0] sh2_reg;

  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  // ==========================================================================
  // Shadow of channel 2 control, holds the prescaler enable
  always @(posedge clock or negedge rstn) begin
    if (!rstn)
      sh2_reg <= 16'h0000;
    else if (wr_strobe && addr == `UCCP_ADDR_CH2_CTRL)
      sh2_reg <= wr_data[15:0];
  end

  // ==========================================================================
  // Assertions
  a_rd_idle_zero: assert property (!$past(rd_strobe) |-> rd_data_reg == 32'h0)
    else $error("read data not zero outside read slot");
  a_rd_upper_zero: assert property (rd_data_reg[31:16] == 16'h0)
    else $error("read data upper half not zero");
  a_rd_ch2_back: assert property (rd_strobe && addr == `UCCP_ADDR_CH2_CTRL
    |=> rd_data_reg == {16'h0, sh2_reg})
    else $error("channel 2 control read back wrong");
  a_rd_unmapped: assert property (rd_strobe && addr == 32'h50000000 |=> rd_data_reg == 32'h0)
    else $error("unmapped read not zero");
  a_prescale_off_low: assert property (!sh2_reg[15] && !$past(sh2_reg[15])
    |-> !divided_core_tick)
    else $error("divided tick while disabled");
  a_tick_spacing: assert property (divided_core_tick |=> !divided_core_tick [*6])
    else $error("divided ticks closer than seven cycles");
  a_baud0_spacing: assert property (baud_tick0 |=> !baud_tick0 [*8])
    else $error("channel 0 baud ticks too close");
  a_baud1_spacing: assert property (baud_tick1 |=> !baud_tick1 [*8])
    else $error("channel 1 baud ticks too close");
  a_baud2_spacing: assert property (baud_tick2 |=> !baud_tick2 [*8])
    else $error("channel 2 baud ticks too close");

  c_divided: cover property (divided_core_tick);
  c_baud2: cover property (baud_tick2);
  c_status_rd: cover property (rd_strobe && addr == `UCCP_ADDR_STATUS);
endmodule

bind uccp_top uccp_top_chk i_chk (.clock(clock), .rstn(rstn), .addr(addr),
  .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
  .rd_data_reg(rd_data_reg), .divided_core_tick(divided_core_tick),
  .baud_tick0(baud_tick0), .baud_tick1(baud_tick1), .baud_tick2(baud_tick2));

// ### dv/tb_uart_clock_source_prescaler.sv
// Testbench for uccp_top: registers, prescaler ratios, baud sources.
// Assumes the design files and uccp_defs.vh are on the include path.
`timescale 1ns/100ps
`include "uccp_defs.vh"

module tb_uart_clock_source_prescaler;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wr_data = 32'h0;
  logic        wr_strobe = 1'b0;
  logic        rd_strobe = 1'b0;
  logic        pbus_tick = 1'b0;
  logic        ext_clk = 1'b0;
  logic        ext_hold = 1'b0;
  logic [1:0]  ext_cnt = 2'h0;
  wire  [31:0] rd_data_reg;
  wire         divided_core_tick;
  wire         baud_tick0;
  wire         baud_tick1;
  wire         baud_tick2;
  int          error_cnt = 0;
  int          checked = 0;
  int          i;
  int          r;
  logic [31:0] v;
  int          tc [7] = '{0, 0, 1, 1, 2, 2, 3};
  int          td [7] = '{1, 15, 1, 15, 1, 7, 0};
  int          bc [4] = '{0, 1, 2, 0};
  int          bs [4] = '{0, 1, 3, 2};
  int          bp [4] = '{64, 192, 1408, 64};

  uccp_top i_dut (.clock(clock), .rstn(rstn), .addr(addr), .wr_data(wr_data),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data_reg(rd_data_reg),
    .pbus_tick(pbus_tick), .external_serial_clock_in(ext_clk),
    .divided_core_tick(divided_core_tick), .baud_tick0(baud_tick0),
    .baud_tick1(baud_tick1), .baud_tick2(baud_tick2));

  // ==========================================================================
  // Clock and source clocks: bus tick every 2 cycles, external rise every 6
  initial forever #10 clock = ~clock;
  always @(posedge clock) begin
    pbus_tick <= ~pbus_tick;
    ext_cnt <= (ext_cnt == 2'h2) ? 2'h0 : ext_cnt + 2'h1;
    if (ext_hold)
      ext_clk <= 1'b0;
    else if (ext_cnt == 2'h2)
      ext_clk <= ~ext_clk;
  end

  // ==========================================================================
  // Tasks
  task check(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge clock);
    wr_strobe <= 1'b0;
  endtask

  task rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clock);
    rd_strobe <= 1'b0;
    #1 check("rd_data_reg", rd_data_reg, e);
  endtask

  function logic sg(input int k);
    case (k)
      0: sg = divided_core_tick;
      1: sg = baud_tick0;
      2: sg = baud_tick1;
      default: sg = baud_tick2;
    endcase
  endfunction

  // Second gap between ticks (third wait), clear of any restart
  task meas(input int k, input int e);
    int n;
    int j;
    for (j = 0; j < 3; j++) begin
      n = 0;
      do begin
        @(posedge clock);
        #1;
        n++;
      end while (sg(k) !== 1'b1 && n < 5000);
    end
    check("tick period", n, e);
  endtask

  // Pin back to plain input for about 100 us after a divided clock switch
  task pin_cycle;
    ext_hold <= 1'b1;
    repeat (5000) @(posedge clock);
    ext_hold <= 1'b0;
  endtask

  task conclude;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #(20 * 40000);
    error_cnt++;
    conclude;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    for (i = 0; i < 3; i++) begin
      rd(`UCCP_ADDR_CH0_CTRL + i * 32'h4000, 32'h0);
      rd(`UCCP_ADDR_CH0_BAUD + i * 32'h4000, 32'h0);
    end
    rd(`UCCP_ADDR_STATUS, 32'h2C);
    rd(32'h50000000, 32'h0);
    wr(`UCCP_ADDR_CH1_CTRL, 32'hFFFF5A5A);
    rd(`UCCP_ADDR_CH1_CTRL, 32'h5A5A);
    // At most one divider field nonzero at a time
    for (i = 0; i < 7; i++) begin
      v = td[i] << 12;
      r = tc[i] == 0 ? td[i] + 6 : tc[i] == 1 ? td[i] + 21 : tc[i] == 2 ? td[i] + 36 : 44;
      wr(`UCCP_ADDR_CH0_CTRL, tc[i] == 0 ? v : 32'h0);
      wr(`UCCP_ADDR_CH1_CTRL, tc[i] == 1 ? v : 32'h0);
      wr(`UCCP_ADDR_CH2_CTRL, 32'h8000 | (tc[i] == 2 ? v : 32'h0));
      rd(`UCCP_ADDR_STATUS, 32'h40 | r);
      meas(0, r);
    end
    wr(`UCCP_ADDR_CH2_CTRL, 32'h0);
    repeat (2) @(posedge clock);
    r = 0;
    repeat (200) begin
      @(posedge clock);
      #1;
      if (divided_core_tick !== 1'b0) r++;
    end
    check("ticks while disabled", r, 0);
    for (i = 0; i < 4; i++) begin
      wr(`UCCP_ADDR_CH0_BAUD + bc[i] * 32'h4000, 32'h1);
      rd(`UCCP_ADDR_CH0_BAUD + bc[i] * 32'h4000, 32'h1);
      wr(`UCCP_ADDR_CH0_CTRL + bc[i] * 32'h4000, (bs[i] << 10) | (bs[i] == 3 ? 32'h8000 : 0));
      if (bs[i] == 3) pin_cycle;
      meas(bc[i] + 1, bp[i]);
    end
    conclude;
  end
endmodule
